// *** common/sig_chan_pkg.sv ***
/*
 * Constants for the subscriber signaling channel handler: register map,
 * control memory codes, command values, field layouts and reset values.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package sig_chan_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFF_DATA_VALUE = 8'h00;
    localparam logic [7:0] OFF_SLOT_ADDRESS = 8'h04;
    localparam logic [7:0] OFF_COMMAND_VALUE = 8'h08;
    localparam logic [7:0] OFF_CM_READBACK = 8'h0c;
    localparam logic [7:0] OFF_CHANGE_QUEUE = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFF_CONFIG = 8'h1c;

    // ==========================================================
    // Control memory codes
    localparam logic [3:0] CODE_UNUSED_US = 4'h0;
    localparam logic [3:0] CODE_SWITCH_64K = 4'h1;
    localparam logic [3:0] CODE_SUB_BITS_10 = 4'h4;
    localparam logic [3:0] CODE_SUB_BITS_76 = 4'h7;
    localparam logic [3:0] CODE_CI_UPSTREAM = 4'h8;
    localparam logic [3:0] CODE_SIG_PREPROC = 4'ha;
    localparam logic [3:0] CODE_SIG_8BIT = 4'hb;

    // ==========================================================
    // Command values
    localparam logic [3:0] CMD_WRITE_CODE_DATA = 4'h7;
    localparam logic [7:0] CMD_SINGLE_TRISTATE = 8'h60;

    // ==========================================================
    // Field layouts
    localparam int ADDR_DIR_BIT = 7;
    localparam int CFG_HANDSHAKE_BIT = 0;
    localparam int CFG_PERIOD_LSB = 8;
    localparam int IRQ_CHANGE_BIT = 0;
    localparam int IRQ_BLOCKED_BIT = 1;
    localparam int QUEUE_EMPTY_BIT = 8;
    localparam logic [7:0] MASK_SIG_6BIT = 8'hfc;
    localparam logic [7:0] MASK_SIG_8BIT = 8'hff;
    localparam logic [7:0] MASK_CI_FIELD = 8'h3c;
    localparam logic [1:0] HS_FORCED_ONES = 2'h3;

    // ==========================================================
    // Reset values, sizes and bus response codes
    localparam logic [7:0] RST_PERIOD_FRAMES = 8'h01;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;
    localparam int QUEUE_DEPTH = 9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rtl/sig_chan.sv ***
/*
 * Pre-processed subscriber channel handler: control memory, tristate
 * memory, downstream slot composer, upstream change detection with a
 * nine-entry change address queue and an AXI4-Lite register slave.
 * Assumes a slot sequencer outside that presents one slot per request,
 * a monitor handler that supplies the handshake bits, and a PCM side
 * that answers a read pointer in the same cycle.
 */
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module sig_chan #(
    parameter int QDEPTH = sig_chan_pkg::QUEUE_DEPTH
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Subscriber side, frame and upstream slots
    input wire logic frame_i,
    input wire logic us_valid_i,
    input wire logic [6:0] us_slot_i,
    input wire logic [7:0] us_data_i,
    output logic us_ready_o,
    // Subscriber side, downstream slots
    input wire logic ds_req_i,
    input wire logic [6:0] ds_slot_i,
    output logic ds_valid_o,
    output logic [7:0] ds_data_o,
    output logic [7:0] ds_oe_o,
    // Monitor feature handler
    input wire logic [7:0] mon_tx_byte_i,
    input wire logic monitor_receive_ack_i,
    input wire logic monitor_transmit_flag_i,
    // PCM side
    output logic [7:0] pcm_rd_ptr_o,
    input wire logic [7:0] pcm_rd_data_i,
    output logic pcm_wr_valid_o,
    output logic [7:0] pcm_wr_ptr_o,
    output logic [7:0] pcm_wr_data_o,
    output logic [7:0] pcm_wr_oe_o,
    // Interrupt
    output logic irq_o
);

    // ==========================================================
    // Helpers
    function automatic logic is_sub_code(input logic [3:0] c);
        return (c >= sig_chan_pkg::CODE_SUB_BITS_10) && (c <= sig_chan_pkg::CODE_SUB_BITS_76);
    endfunction

    // Bit offset of a 2-bit sub slot inside the PCM byte
    function automatic logic [2:0] sub_shift(input logic [3:0] c);
        return 3'({c[1:0], 1'b0});
    endfunction

    function automatic logic is_switch(input logic [3:0] c);
        return (c == sig_chan_pkg::CODE_SWITCH_64K) || is_sub_code(c);
    endfunction

    // ==========================================================
    // Register and memory state
    logic [7:0] data_value_q, data_value_d;
    logic [7:0] slot_address_q, slot_address_d;
    logic handshake_q, handshake_d;
    logic [7:0] period_q, period_d;
    logic [1:0] irq_stat_q, irq_stat_d;
    logic [1:0] irq_mask_q, irq_mask_d;
    logic [11:0] cm_even [128];
    logic [11:0] cm_odd [128];
    logic [7:0] tristate_mem [256];
    logic [7:0] queue_mem [QDEPTH];
    logic [3:0] q_wr_q, q_wr_d, q_rd_q, q_rd_d, q_cnt_q, q_cnt_d;
    logic [7:0] frame_cnt_q, frame_cnt_d;
    logic sample_q, sample_d;

    // ==========================================================
    // AXI4-Lite slave
    logic aw_held_q, aw_held_d, w_held_q, w_held_d, bvalid_q, bvalid_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic wstrb0_q, wstrb0_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_fire, rd_fire, wr_mapped, cmd_fire, q_pop;
    logic [7:0] wbyte;

    assign s_axi_awready_o = !aw_held_q;
    assign s_axi_wready_o = !w_held_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = !rvalid_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rresp_o = rresp_q;
    assign s_axi_rdata_o = rdata_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign rd_fire = s_axi_arvalid_i && !rvalid_q;
    assign wbyte = wdata_q[7:0];
    assign wr_mapped = (awaddr_q <= sig_chan_pkg::OFF_CONFIG) && (awaddr_q[1:0] == 2'h0);
    assign cmd_fire = wr_fire && wstrb0_q && (awaddr_q == sig_chan_pkg::OFF_COMMAND_VALUE);
    assign q_pop = rd_fire && (s_axi_araddr_i == sig_chan_pkg::OFF_CHANGE_QUEUE)
        && (q_cnt_q != 4'h0);

    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb0_d = wstrb0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        // Address and data are taken in either order
        if (s_axi_awvalid_i && !aw_held_q) begin
            aw_held_d = 1'b1;
            awaddr_d = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_held_q) begin
            w_held_d = 1'b1;
            wdata_d = s_axi_wdata_i;
            wstrb0_d = s_axi_wstrb_i[0];
        end
        if (wr_fire) begin
            bvalid_d = 1'b1;
            bresp_d = wr_mapped ? sig_chan_pkg::RESP_OKAY : sig_chan_pkg::RESP_SLVERR;
        end
        if (bvalid_q && s_axi_bready_i) begin
            bvalid_d = 1'b0;
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
        end
    end

    always_comb begin
        logic [11:0] cm_word;
        cm_word = slot_address_q[0] ? cm_odd[slot_address_q[7:1]] : cm_even[slot_address_q[7:1]];
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (rvalid_q && s_axi_rready_i) begin
            rvalid_d = 1'b0;
        end
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rresp_d = sig_chan_pkg::RESP_OKAY;
            unique case (s_axi_araddr_i)
                sig_chan_pkg::OFF_DATA_VALUE: rdata_d = {24'h0, data_value_q};
                sig_chan_pkg::OFF_SLOT_ADDRESS: rdata_d = {24'h0, slot_address_q};
                sig_chan_pkg::OFF_COMMAND_VALUE: rdata_d = 32'h0;
                sig_chan_pkg::OFF_CM_READBACK: rdata_d = {20'h0, cm_word};
                sig_chan_pkg::OFF_CHANGE_QUEUE: rdata_d = {23'h0, q_cnt_q == 4'h0,
                    queue_mem[q_rd_q]};
                sig_chan_pkg::OFF_IRQ_STATUS: rdata_d = {30'h0, irq_stat_q};
                sig_chan_pkg::OFF_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
                sig_chan_pkg::OFF_CONFIG: rdata_d = {16'h0, period_q, 7'h0, handshake_q};
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = sig_chan_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // ==========================================================
    // Upstream change detection
    logic [6:0] us_pair;
    logic [11:0] us_even, us_odd;
    logic [7:0] sig_mask, new_sig, ci_new;
    logic us_odd_slot, us_take, cm_even_we, cm_odd_we, q_push, blocked;
    logic [11:0] cm_even_wd, cm_odd_wd;
    logic [6:0] cm_even_wa, cm_odd_wa;

    // Upstream half of the map, even and odd entries of the pair
    assign us_pair = {1'b1, us_slot_i[6:1]};
    assign us_even = cm_even[us_pair];
    assign us_odd = cm_odd[us_pair];
    // A command write owns the memory ports for that cycle
    assign us_ready_o = !cmd_fire;
    assign us_take = us_valid_i && us_ready_o;
    assign us_odd_slot = us_slot_i[0];
    assign sig_mask = (us_even[11:8] == sig_chan_pkg::CODE_SIG_PREPROC) ?
        sig_chan_pkg::MASK_SIG_6BIT : sig_chan_pkg::MASK_SIG_8BIT;
    assign new_sig = us_data_i & sig_mask;
    assign ci_new = us_data_i & sig_chan_pkg::MASK_CI_FIELD;

    always_comb begin
        cm_even_we = 1'b0;
        cm_odd_we = 1'b0;
        cm_even_wa = slot_address_q[7:1];
        cm_odd_wa = slot_address_q[7:1];
        cm_even_wd = {wbyte[3:0], data_value_q};
        cm_odd_wd = {wbyte[3:0], data_value_q};
        q_push = 1'b0;
        blocked = 1'b0;
        if (cmd_fire && (wbyte[7:4] == sig_chan_pkg::CMD_WRITE_CODE_DATA)) begin
            cm_even_we = !slot_address_q[0];
            cm_odd_we = slot_address_q[0];
        end else if (us_take && us_odd_slot) begin
            cm_even_wa = us_pair;
            cm_odd_wa = us_pair;
            if (us_even[11:8] == sig_chan_pkg::CODE_CI_UPSTREAM) begin
                // C/I change against previous frame
                if (ci_new != (us_even[7:0] & sig_chan_pkg::MASK_CI_FIELD)) begin
                    blocked = (q_cnt_q == 4'(QDEPTH));
                    // When the queue is full the change stays pending
                    cm_even_we = !blocked;
                    q_push = !blocked;
                    cm_even_wd = {us_even[11:8], (us_even[7:0] & ~sig_chan_pkg::MASK_CI_FIELD)
                        | ci_new};
                end
            end else if (sample_q && (us_even[11:9] == 3'h5) && (us_odd[11:8] == us_even[11:8]))
            begin
                // Actual value always tracks; stable needs two equal looks
                cm_even_we = 1'b1;
                cm_even_wd = {us_even[11:8], new_sig};
                if ((new_sig == (us_even[7:0] & sig_mask))
                    && (new_sig != (us_odd[7:0] & sig_mask))) begin
                    blocked = (q_cnt_q == 4'(QDEPTH));
                    cm_odd_we = !blocked;
                    q_push = !blocked;
                    cm_odd_wd = {us_odd[11:8], new_sig};
                end
            end
        end
    end

    // Upstream PCM switching of the odd slot
    logic pcm_wr_valid_q;
    logic [7:0] pcm_wr_ptr_q, pcm_wr_data_q, pcm_wr_oe_q;
    logic pcm_wr_valid_d;
    logic [7:0] pcm_wr_ptr_d, pcm_wr_data_d, pcm_wr_oe_d;
    always_comb begin
        pcm_wr_valid_d = 1'b0;
        pcm_wr_ptr_d = pcm_wr_ptr_q;
        pcm_wr_data_d = pcm_wr_data_q;
        pcm_wr_oe_d = pcm_wr_oe_q;
        if (us_take && us_odd_slot && is_switch(us_odd[11:8])) begin
            pcm_wr_valid_d = 1'b1;
            pcm_wr_ptr_d = us_odd[7:0];
            if (is_sub_code(us_odd[11:8])) begin
                // D bits sit at 7..6 of the subscriber slot
                pcm_wr_data_d = 8'({6'h0, us_data_i[7:6]} << sub_shift(us_odd[11:8]));
                pcm_wr_oe_d = 8'(8'h03 << sub_shift(us_odd[11:8]));
            end else begin
                pcm_wr_data_d = us_data_i;
                pcm_wr_oe_d = tristate_mem[us_odd[7:0]];
            end
        end
    end

    assign pcm_wr_valid_o = pcm_wr_valid_q;
    assign pcm_wr_ptr_o = pcm_wr_ptr_q;
    assign pcm_wr_data_o = pcm_wr_data_q;
    assign pcm_wr_oe_o = pcm_wr_oe_q;

    // ==========================================================
    // Downstream slot composer
    logic [11:0] ds_even, ds_odd;
    logic [1:0] hs_bits;
    logic ds_valid_d;
    logic [7:0] ds_data_d, ds_oe_d;
    logic ds_valid_q;
    logic [7:0] ds_data_q, ds_oe_q;

    assign ds_even = cm_even[{1'b0, ds_slot_i[6:1]}];
    assign ds_odd = cm_odd[{1'b0, ds_slot_i[6:1]}];
    assign pcm_rd_ptr_o = ds_odd[7:0];
    assign hs_bits = handshake_q ? {monitor_receive_ack_i, monitor_transmit_flag_i}
        : sig_chan_pkg::HS_FORCED_ONES;
    assign ds_valid_o = ds_valid_q;
    assign ds_data_o = ds_data_q;
    assign ds_oe_o = ds_oe_q;

    always_comb begin
        ds_valid_d = ds_req_i;
        ds_data_d = ds_data_q;
        ds_oe_d = ds_oe_q;
        if (ds_req_i) begin
            ds_oe_d = 8'hff;
            if (!ds_slot_i[0]) begin
                ds_data_d = mon_tx_byte_i;
            end else if (ds_even[11:8] != sig_chan_pkg::CODE_SIG_PREPROC) begin
                ds_data_d = 8'hff;
                ds_oe_d = 8'h00;
            end else if (ds_odd[11:8] == sig_chan_pkg::CODE_SWITCH_64K) begin
                ds_data_d = {pcm_rd_data_i[7:2], pcm_rd_data_i[1:0] & hs_bits};
            end else if (is_sub_code(ds_odd[11:8])) begin
                ds_data_d = {2'(pcm_rd_data_i >> sub_shift(ds_odd[11:8])),
                    ds_even[5:2], ds_even[1:0] & hs_bits};
            end else begin
                // Held value goes out every frame
                ds_data_d = {ds_even[7:2], ds_even[1:0] & hs_bits};
            end
        end
    end

    // ==========================================================
    // Control registers, queue, sampling and interrupt
    logic [1:0] irq_set;
    assign irq_set = {blocked, q_push};
    assign irq_o = |(irq_stat_q & irq_mask_q);

    always_comb begin
        data_value_d = data_value_q;
        slot_address_d = slot_address_q;
        handshake_d = handshake_q;
        period_d = period_q;
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q;
        if (wr_fire && wstrb0_q) begin
            unique case (awaddr_q)
                sig_chan_pkg::OFF_DATA_VALUE: data_value_d = wbyte;
                sig_chan_pkg::OFF_SLOT_ADDRESS: slot_address_d = wbyte;
                sig_chan_pkg::OFF_IRQ_STATUS: irq_stat_d = irq_stat_q & ~wbyte[1:0];
                sig_chan_pkg::OFF_IRQ_MASK: irq_mask_d = wbyte[1:0];
                sig_chan_pkg::OFF_CONFIG: begin
                    handshake_d = wbyte[sig_chan_pkg::CFG_HANDSHAKE_BIT];
                    period_d = wdata_q[sig_chan_pkg::CFG_PERIOD_LSB +: 8];
                end
                default: ;
            endcase
        end
        // Set wins over a simultaneous clear
        irq_stat_d = irq_stat_d | irq_set;
        q_wr_d = q_push ? ((q_wr_q == 4'(QDEPTH - 1)) ? 4'h0 : q_wr_q + 4'h1) : q_wr_q;
        q_rd_d = q_pop ? ((q_rd_q == 4'(QDEPTH - 1)) ? 4'h0 : q_rd_q + 4'h1) : q_rd_q;
        q_cnt_d = q_cnt_q + {3'h0, q_push} - {3'h0, q_pop};
        // One sampling frame out of every period frames
        frame_cnt_d = frame_cnt_q;
        sample_d = sample_q;
        if (frame_i) begin
            sample_d = (frame_cnt_q + 8'h1 >= period_q);
            frame_cnt_d = sample_d ? 8'h0 : frame_cnt_q + 8'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (cm_even_we) cm_even[cm_even_wa] <= cm_even_wd;
        if (cm_odd_we) cm_odd[cm_odd_wa] <= cm_odd_wd;
        if (cmd_fire && (wbyte == sig_chan_pkg::CMD_SINGLE_TRISTATE)) begin
            tristate_mem[slot_address_q] <= data_value_q;
        end
        if (q_push) queue_mem[q_wr_q] <= {1'b1, us_slot_i};
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 32'h0;
            data_value_q <= 8'h00;
            slot_address_q <= 8'h00;
            handshake_q <= 1'b0;
            period_q <= sig_chan_pkg::RST_PERIOD_FRAMES;
            irq_stat_q <= 2'h0;
            irq_mask_q <= sig_chan_pkg::RST_IRQ_MASK;
            q_wr_q <= 4'h0;
            q_rd_q <= 4'h0;
            q_cnt_q <= 4'h0;
            frame_cnt_q <= 8'h00;
            sample_q <= 1'b0;
            pcm_wr_valid_q <= 1'b0;
            pcm_wr_ptr_q <= 8'h00;
            pcm_wr_data_q <= 8'h00;
            pcm_wr_oe_q <= 8'h00;
            ds_valid_q <= 1'b0;
            ds_data_q <= 8'h00;
            ds_oe_q <= 8'h00;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb0_q <= wstrb0_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            data_value_q <= data_value_d;
            slot_address_q <= slot_address_d;
            handshake_q <= handshake_d;
            period_q <= period_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            q_wr_q <= q_wr_d;
            q_rd_q <= q_rd_d;
            q_cnt_q <= q_cnt_d;
            frame_cnt_q <= frame_cnt_d;
            sample_q <= sample_d;
            pcm_wr_valid_q <= pcm_wr_valid_d;
            pcm_wr_ptr_q <= pcm_wr_ptr_d;
            pcm_wr_data_q <= pcm_wr_data_d;
            pcm_wr_oe_q <= pcm_wr_oe_d;
            ds_valid_q <= ds_valid_d;
            ds_data_q <= ds_data_d;
            ds_oe_q <= ds_oe_d;
        end
    end

endmodule // sig_chan

// *** test/sub_codec.sv ***
/* Subscriber-side codec model: presents one upstream slot per send request.
   Assumes the handler's ready answer gates acceptance. */
`timescale 1ns/1ns
module sub_codec (
    input wire logic clock_i,
    input wire logic send_i,
    input wire logic [6:0] slot_i,
    input wire logic [7:0] sig_i,
    input wire logic ready_i,
    output logic valid_o = 1'b0,
    output logic [6:0] slot_o = 7'h00,
    output logic [7:0] data_o = 8'h00
);
    always @(posedge clock_i) begin
        if (send_i) begin
            valid_o <= 1'b1;
            slot_o <= slot_i;
            data_o <= sig_i;
        end else if (valid_o && ready_i) begin
            valid_o <= 1'b0;
            // Released line must not look like the last slot
            data_o <= ~data_o;
        end
    end
endmodule // sub_codec

// *** test/sig_chan_assertions.sv ***
/* Port checker for the signaling channel handler.
   Assumes it is bound to every handler instance. */
`timescale 1ns/1ns
module sig_chan_checker (
    input wire logic clock_i, rst_b_i, s_axi_awvalid_i, s_axi_awready_o,
    input wire logic s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i,
    input wire logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i,
    input wire logic ds_req_i, ds_valid_o, us_valid_i, us_ready_o, pcm_wr_valid_o,
    input wire logic [6:0] ds_slot_i, us_slot_i,
    input wire logic [7:0] ds_data_o, mon_tx_byte_i
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    ds_answer_a: assert property (ds_req_i |=> ds_valid_o)
        else $error("downstream request unanswered");
    ds_quiet_a: assert property (!ds_req_i |=> !ds_valid_o)
        else $error("downstream answer without request");
    ds_monitor_a: assert property (ds_req_i && !ds_slot_i[0] |=>
        ds_data_o == $past(mon_tx_byte_i)) else $error("even slot not monitor byte");
    pcm_cause_a: assert property (pcm_wr_valid_o |->
        $past(us_valid_i && us_ready_o && us_slot_i[0])) else $error("pcm write uncaused");
    b_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write unanswered");
    b_release_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("write response not released");
    r_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read unanswered");
    r_release_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("read response not released");
endmodule // sig_chan_checker
bind sig_chan sig_chan_checker chk_i (.*);

// *** test/sig_chan_tb_top.sv ***
/* Self-checking bench for the signaling channel handler.
   Assumes a PCM side that answers the read pointer at once. */
`timescale 1ns/1ns
module sig_chan_tb_top;
    logic clock_i = 0, rst_b_i = 0, frame_i = 0, ds_req_i = 0, snd = 0;
    logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0, s_axi_rready_i = 0;
    logic s_axi_arvalid_i = 0, monitor_receive_ack_i = 1, monitor_transmit_flag_i = 0;
    logic us_valid_i, us_ready_o, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_arready_o, s_axi_rvalid_o, ds_valid_o, pcm_wr_valid_o, irq_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
    logic [3:0] s_axi_wstrb_i = 4'h1;
    logic [6:0] us_slot_i, ds_slot_i = 7'h00, sl = 7'h0b;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, us_data_i, ds_data_o;
    logic [7:0] ds_oe_o, mon_tx_byte_i = 8'h5a, pcm_rd_ptr_o, pcm_rd_data_i, sv = 8'h00;
    logic [7:0] pcm_wr_ptr_o, pcm_wr_data_o, pcm_wr_oe_o;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rdat;
    int n_mismatch = 0, checked = 0;
    always #25 clock_i = ~clock_i;
    // Far side sends the two low bits as ones
    assign pcm_rd_data_i = {pcm_rd_ptr_o[5:0], 2'h3};
    sig_chan dut (.*);
    sub_codec codec (.clock_i(clock_i), .send_i(snd), .slot_i(sl), .sig_i(sv),
        .ready_i(us_ready_o), .valid_o(us_valid_i), .slot_o(us_slot_i), .data_o(us_data_i));
    task automatic tally_and_finish();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus access; called just after a rising edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        logic ta, tw, tr, done;
        s_axi_awaddr_i <= a;
        s_axi_araddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= w;
        s_axi_wvalid_i <= w;
        s_axi_arvalid_i <= !w;
        s_axi_bready_i <= w;
        s_axi_rready_i <= !w;
        for (i = 0; i < 40; i++) begin
            @(negedge clock_i);
            ta = s_axi_awready_o;
            tw = s_axi_wready_o;
            tr = s_axi_arready_o;
            done = w ? s_axi_bvalid_o : s_axi_rvalid_o;
            resp = w ? s_axi_bresp_o : s_axi_rresp_o;
            rdat = s_axi_rdata_o;
            @(posedge clock_i);
            if (ta) s_axi_awvalid_i <= 1'b0;
            if (tw) s_axi_wvalid_i <= 1'b0;
            if (tr) s_axi_arvalid_i <= 1'b0;
            if (done) break;
        end
        s_axi_bready_i <= 1'b0;
        s_axi_rready_i <= 1'b0;
        if (i == 40) begin
            n_mismatch++;
            tally_and_finish();
        end
        @(posedge clock_i);
    endtask
    task automatic cm(input logic [7:0] a, input logic [3:0] code, input logic [7:0] d);
        acc(1, 8'h04, {24'h0, a});
        acc(1, 8'h00, {24'h0, d});
        acc(1, 8'h08, {24'h0, 4'h7, code});
    endtask
    task automatic dq(input logic [6:0] s);
        ds_slot_i <= s;
        ds_req_i <= 1'b1;
        @(posedge clock_i);
        ds_req_i <= 1'b0;
        @(posedge clock_i);
    endtask
    // One sampling frame carrying one odd upstream slot
    task automatic up(input logic [7:0] v);
        frame_i <= 1'b1;
        @(posedge clock_i);
        frame_i <= 1'b0;
        sv <= v;
        snd <= 1'b1;
        @(posedge clock_i);
        snd <= 1'b0;
        repeat (4) @(posedge clock_i);
    endtask
    initial begin
        repeat (4) @(posedge clock_i);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        acc(0, 8'h1c, 0); chk("config", rdat, 32'h100);
        acc(0, 8'h18, 0); chk("mask", rdat, 32'h0);
        acc(0, 8'h20, 0); chk("unmapped", resp, 32'h2);
        cm(8'h0a, 4'ha, 8'h47); acc(0, 8'h0c, 0); chk("cm", rdat, 32'ha47);
        cm(8'h0b, 4'h1, 8'h2c); dq(7'h0b); chk("switched", ds_data_o, 8'hb3);
        chk("ds oe", ds_oe_o, 8'hff);
        dq(7'h0a); chk("monitor", ds_data_o, 8'h5a);
        cm(8'h0b, 4'hb, 8'h00); dq(7'h0b); chk("sig6", ds_data_o, 8'h47);
        acc(1, 8'h1c, 32'h101); dq(7'h0b); chk("handshake", ds_data_o, 8'h46);
        cm(8'h8a, 4'ha, 8'hdf); cm(8'h8b, 4'ha, 8'hdf); acc(1, 8'h18, 1);
        up(8'h47); chk("single look", irq_o, 0);
        up(8'h47); chk("change irq", irq_o, 1);
        acc(0, 8'h10, 0); chk("queue", rdat, 32'h8b);
        acc(1, 8'h14, 1); chk("irq clear", irq_o, 0);
        // Two low bits of the upstream PCM slot left undriven
        acc(1, 8'h04, 32'h24); acc(1, 8'h00, 32'hfc); acc(1, 8'h08, 32'h60);
        cm(8'h8b, 4'h1, 8'h24); up(8'h96); chk("pcm data", pcm_wr_data_o, 8'h96);
        chk("pcm oe", pcm_wr_oe_o, 8'hfc); chk("pcm ptr", pcm_wr_ptr_o, 8'h24);
        cm(8'h8a, 4'h8, 8'hff); cm(8'h8b, 4'h5, 8'ha4); up(8'hc3);
        chk("sub data", pcm_wr_data_o, 8'h0c); chk("sub oe", pcm_wr_oe_o, 8'h0c);
        chk("ci irq", irq_o, 1);
        acc(0, 8'h10, 0); chk("ci queue", rdat, 32'h8b);
        acc(1, 8'h14, 1); acc(1, 8'h1c, 32'h100);
        cm(8'h0a, 4'ha, 8'h45); dq(7'h0b); chk("sig8 down", ds_data_o, 8'h45);
        cm(8'h8a, 4'hb, 8'hd6); cm(8'h8b, 4'hb, 8'hd6); up(8'h29); up(8'h29);
        acc(0, 8'h10, 0); chk("sig8 queue", rdat, 32'h8b);
        tally_and_finish();
    end
endmodule // sig_chan_tb_top
